// ==== shared/static_mem_pkg.sv ====
// Purpose: shared constants and types for the static memory controller
// Assumes: one master clock, eight chip selects, 26-bit memory address
// Notes: slow-clock waveform figures are fixed cycle counts
package static_mem_pkg;
  localparam int NUM_CS = 8;
  localparam int ADDR_W = 26;
  // wait mode selector encodings
  localparam logic [1:0] WAIT_OFF = 2'h0;
  localparam logic [1:0] WAIT_FROZEN = 2'h2;
  localparam logic [1:0] WAIT_READY = 2'h3;
  // data bus width encodings
  localparam logic [1:0] BUS_W16 = 2'h1;
  localparam logic [1:0] BUS_W32 = 2'h2;
  // byte access type: byte-select mode
  localparam logic BAT_BYTE_SEL = 1'h0;
  // smallest page is 4 bytes, so page bits start at bit 2
  localparam int PAGE_BASE_LSB = 2;
  // fixed slow-clock waveforms, in master clock cycles
  localparam logic [7:0] SLOW_STRB_SETUP = 8'h01;
  localparam logic [8:0] SLOW_STRB_PULSE = 9'h001;
  localparam logic [7:0] SLOW_CS_SETUP = 8'h00;
  localparam logic [8:0] SLOW_CS_RD_PULSE = 9'h002;
  localparam logic [8:0] SLOW_CS_WR_PULSE = 9'h003;
  localparam logic [9:0] SLOW_RD_CYCLE = 10'h002;
  localparam logic [9:0] SLOW_WR_CYCLE = 10'h003;
  // wait synchroniser depth and idle level
  localparam int WAIT_SYNC_STAGES = 2;
  localparam logic WAIT_IDLE_LVL = 1'h1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GAP = 2'b01,
    ST_ACCESS = 2'b10,
    ST_PAGE_OPEN = 2'b11
  } ctrl_state_t;
endpackage

// ==== test/static_mem_dev.sv ====
// Purpose: behavioural async memory that stretches accesses by wait
// Assumes: wait line has a pull-up, so a released line reads high
// Notes: wait starts one clock after the chosen strobe edge
`timescale 1ns/10ps
module static_mem_dev
(
  input wire logic clk_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic trig_on_rise_i,
  input wire logic [7:0] wait_len_i,
  output logic ext_wait_n_o
);
  logic strb_r = 1'h1;
  logic [7:0] cnt_r = 8'h00;
  logic strb_nxt;
  assign strb_nxt = read_strobe_n_i & write_strobe_n_i;
  // one clock of latency, far below the programmed pulse
  always @(posedge clk_i)
  begin
    strb_r <= strb_nxt;
    if (strb_r != strb_nxt && strb_nxt == trig_on_rise_i)
      cnt_r <= wait_len_i;
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  end
  // a released line floats up to the pull-up level
  assign ext_wait_n_o = (cnt_r == 8'h00);
endmodule // static_mem_dev

// ==== test/tb_static_mem_ctrl.sv ====
// Purpose: self-checking bench for the static memory sequencer
// Assumes: wait pin from the device model; config changed only when idle, except slow clock dropped mid-transfer
// Notes: access length counted in falling edges from take to done
`timescale 1ns/10ps
module tb_static_mem_ctrl
  import static_mem_pkg::*;
;
  logic clk, rst, vld, wr, pen, byte_access_type, slow, rmode, wmode, rdy, done, rdn;
  logic wrn, trig, waitn, drop_slow;
  logic [2:0] cs;
  logic [25:0] addr, maddr;
  logic [3:0] be, bsn;
  logic [5:0] rss, crs, wss, cws;
  logic [6:0] rsp, crp, wsp, cwp;
  logic [8:0] rcl, wcl;
  logic [1:0] wsel, psel, dbw;
  logic [7:0] csn, wlen;
  int miscompares, compares, len, rd_lo, wr_lo, cs_lo;
  static_mem_ctrl i_static_mem_ctrl
  (
    .CLOCK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(vld), .REQ_WRITE_I(wr),
    .REQ_CS_I(cs), .REQ_ADDR_I(addr), .REQ_BE_I(be),
    .RD_STROBE_SETUP_I(rss), .RD_STROBE_PULSE_I(rsp), .RD_CYCLE_LEN_I(rcl),
    .CS_RD_SETUP_I(crs), .CS_RD_PULSE_I(crp), .WR_STROBE_SETUP_I(wss),
    .WR_STROBE_PULSE_I(wsp), .WR_CYCLE_LEN_I(wcl), .CS_WR_SETUP_I(cws),
    .CS_WR_PULSE_I(cwp), .READ_MODE_I(rmode), .WRITE_MODE_I(wmode),
    .WAIT_MODE_SEL_I(wsel), .PAGE_MODE_EN_I(pen), .PAGE_SIZE_SEL_I(psel),
    .BYTE_ACCESS_TYPE_I(byte_access_type), .DATA_BUS_WIDTH_I(dbw), .SLOW_CLOCK_I(slow),
    .EXT_WAIT_N_I(waitn), .REQ_READY_O(rdy), .DONE_O(done),
    .CHIP_SEL_N_O(csn), .READ_STROBE_N_O(rdn), .WRITE_STROBE_N_O(wrn),
    .BYTE_SEL_N_O(bsn), .MEM_ADDR_O(maddr)
  );
  static_mem_dev i_static_mem_dev
  (
    .clk_i(clk), .read_strobe_n_i(rdn), .write_strobe_n_i(wrn),
    .trig_on_rise_i(trig), .wait_len_i(wlen), .ext_wait_n_o(waitn)
  );
  // free-running master clock, 5 ns period
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // compare helper, case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h exp %0h", $time, msg,
               seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask
  // one request, held until taken; counts pin low cycles until done
  // pins lag the counter by one clock, so the done cycle is counted too
  task automatic access(input logic w, input logic [2:0] c,
                        input logic [25:0] a);
    int n;
    n = 0;
    wr = w;
    cs = c;
    addr = a;
    vld = 1'h1;
    while (rdy !== 1'h1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    vld = 1'h0;
    if (drop_slow)
      slow = 1'h0;
    len = 1;
    rd_lo = 0;
    wr_lo = 0;
    cs_lo = 0;
    while (done !== 1'h1 && len < 300)
    begin
      @(negedge clk);
      len++;
      rd_lo += (rdn === 1'h0);
      wr_lo += (wrn === 1'h0);
      cs_lo += (csn[c] === 1'h0);
    end
    if (n >= 200 || len >= 300)
    begin
      miscompares++;
      results();
    end
  endtask
  // wait selector table: mode, trigger edge, wait length, bounds, strobe
  task automatic t_wait();
    logic [1:0] m [7] = '{WAIT_OFF, 2'h1, WAIT_FROZEN, WAIT_FROZEN,
                          WAIT_READY, WAIT_READY, WAIT_READY};
    int t [7] = '{0, 0, 0, 1, 0, 1, 0};
    int wl [7] = '{14, 14, 4, 4, 2, 4, 14};
    int lo [7] = '{15, 15, 19, 15, 15, 15, 20};
    int hi [7] = '{15, 15, 19, 15, 15, 15, 26};
    int sl [7] = '{10, 10, 14, 10, 10, 10, 0};
    for (int w = 0; w < 2; w++)
      for (int i = 0; i < 7; i++)
      begin
        wsel = m[i];
        trig = t[i][0];
        wlen = 8'(wl[i]);
        access(w[0], 3'h1, 26'h0000_0040);
        chk(32'(len >= lo[i] && len <= hi[i]), 32'h1, "wait len");
        if (sl[i] != 0)
          chk(w ? wr_lo : rd_lo, sl[i], "strobe low");
        idle(16);
      end
    // wait raised in a long hold phase must not stretch the access
    rcl = 9'h014;
    wsel = WAIT_FROZEN;
    trig = 1'h1;
    wlen = 8'h04;
    access(1'h0, 3'h1, 26'h0000_0040);
    chk(len, 21, "hold wait");
    rcl = 9'h00e;
    idle(16);
    // select-controlled read: ready test moves to the select's last cycle
    rmode = 1'h0;
    wsel = WAIT_READY;
    trig = 1'h0;
    wlen = 8'h0e;
    access(1'h0, 3'h1, 26'h0000_0040);
    chk(len, 22, "cs controlled");
    rmode = 1'h1;
    idle(16);
    $display("t_wait done");
  endtask
  // fixed slow waveforms, entry and exit gaps, exit mid-transfer
  task automatic t_slow();
    wsel = WAIT_OFF;
    slow = 1'h1;
    access(1'h0, 3'h1, 26'h0000_0080);
    chk(len, 4, "slow entry");
    access(1'h0, 3'h1, 26'h0000_0080);
    chk(len, 3, "slow read");
    chk(rd_lo, 1, "slow rd strobe");
    chk(cs_lo, 2, "slow rd select");
    access(1'h1, 3'h1, 26'h0000_0080);
    chk(len, 4, "slow write");
    chk(wr_lo, 1, "slow wr strobe");
    chk(cs_lo, 3, "slow wr select");
    drop_slow = 1'h1;
    access(1'h0, 3'h1, 26'h0000_0080);
    drop_slow = 1'h0;
    chk(len, 3, "slow finish");
    access(1'h0, 3'h1, 26'h0000_0080);
    chk(len, 16, "slow exit");
    $display("t_slow done");
  endtask
  // page bursts: short first access on purpose, hits, breaks, sizes
  task automatic t_page();
    logic [25:0] a;
    pen = 1'h1;
    psel = 2'h1;
    dbw = BUS_W32;
    byte_access_type = BAT_BYTE_SEL;
    be = 4'h5;
    crp = 7'h03;
    access(1'h0, 3'h1, 26'h0000_0100);
    chk(len, 4, "page first");
    chk({csn[1], rdn}, 2'h0, "page held");
    access(1'h0, 3'h1, 26'h0000_0107);
    chk(len, 11, "page hit");
    chk(maddr, 26'h0000_0104, "low bits");
    chk(bsn, 4'ha, "byte sel");
    access(1'h0, 3'h1, 26'h0000_0108);
    chk(len, 5, "page miss");
    access(1'h0, 3'h2, 26'h0000_0108);
    chk(len, 5, "cs change");
    access(1'h0, 3'h1, 26'h0000_0108);
    chk(len, 5, "cs back");
    for (int ps = 0; ps < 4; ps++)
    begin
      psel = ps[1:0];
      a = 26'(32'h0000_1000 * (ps + 1));
      access(1'h0, 3'h1, a);
      chk(len, 5, "size new");
      access(1'h0, 3'h1, a + 26'((4 << ps) - 1));
      chk(len, 11, "size hit");
      access(1'h0, 3'h1, a + 26'(4 << ps));
      chk(len, 5, "size miss");
    end
    pen = 1'h0;
    idle(4);
    chk(csn, 8'hff, "page closed");
    dbw = BUS_W16;
    access(1'h0, 3'h1, 26'h0000_0100);
    access(1'h0, 3'h1, 26'h0000_0101);
    chk(len, 15, "no page");
    chk(maddr, 26'h0000_0100, "low bit 16");
    $display("t_page done");
  endtask
  // main sequence; hold of 3 and pulse of 10 suit the wait latency
  initial
  begin
    miscompares = 0;
    compares = 0;
    drop_slow = 1'h0;
    rst = 1'h1;
    vld = 1'h0;
    wr = 1'h0;
    cs = 3'h0;
    addr = 26'h0;
    be = 4'hf;
    rss = 6'h01;
    rsp = 7'h0a;
    rcl = 9'h00e;
    crs = 6'h00;
    crp = 7'h0d;
    wss = 6'h01;
    wsp = 7'h0a;
    wcl = 9'h00e;
    cws = 6'h00;
    cwp = 7'h0d;
    rmode = 1'h1;
    wmode = 1'h1;
    wsel = WAIT_OFF;
    pen = 1'h0;
    psel = 2'h0;
    byte_access_type = 1'h1;
    dbw = BUS_W16;
    slow = 1'h0;
    trig = 1'h0;
    wlen = 8'h00;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    t_wait();
    t_slow();
    t_page();
    results();
  end
endmodule // tb_static_mem_ctrl

// ==== verilog/ext_wait_sync.sv ====
// Purpose: two-stage resynchroniser for the external wait pin
// Assumes: wait pin is asynchronous to the master clock
// Notes: only the second stage is visible outside
`timescale 1ns/10ps
module ext_wait_sync
  import static_mem_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_wait_n_i,
  output logic wait_n_sync_o
);
  logic meta_r;
  // first stage feeds the second and nothing else
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= WAIT_IDLE_LVL; // R26
      wait_n_sync_o <= WAIT_IDLE_LVL;
    end
    else
    begin
      meta_r <= ext_wait_n_i; // R9
      wait_n_sync_o <= meta_r;
    end
  end

  property p_sync_delay;
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i, 2) == 1'b0 |-> wait_n_sync_o == $past(ext_wait_n_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // R9
    else $error("wait sync is not two cycles");
endmodule // ext_wait_sync

// ==== verilog/static_mem_ctrl.sv ====
// Purpose: static memory access sequencer with wait, slow clock, page mode
// Assumes: config ports stable during an access; requests from same clock
// Notes: pins follow the internal cycle counter by one clock
`timescale 1ns/10ps
// What this block does
// R1 - wait selector 00 ignores the wait pin
// R2 - 10 selects frozen, 11 selects ready
// R3 - wait only sampled in controlling pulse
// R4 - software programs hold when wait used
// R5 - no wait with page or slow mode
// R6 - frozen: counters and outputs hold while waiting
// R7 - ready: test at last pulse cycle
// R8 - wait outside that point leaves length
// R9 - wait pin resynchronised over two cycles
// R10 - software keeps pulse above wait latency
// R11 - slow clock overrides programmed waveforms everywhere
// R12 - slow reads: 1,1,0,2 and cycle 2
// R13 - slow writes: 1,1,0,3 and cycle 3
// R14 - transfer in flight keeps slow parameters
// R15 - page bursts only with page enable
// R16 - pages aligned, page bits 25 down
// R17 - low address bits ignored per width
// R18 - page read: strobe and select together
// R19 - first access long, in-page access short
// R20 - byte access type still applies
// R21 - same select and page: short access
// R22 - page break on change or deselect
// R23 - slow mode change inserts one wait
// R24 - read mode picks controlling signal
// R25 - page size 0..3 means 4..32
// R26 - synchroniser flops reset high
module static_mem_ctrl
  import static_mem_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [2:0] REQ_CS_I,
  input wire logic [25:0] REQ_ADDR_I,
  input wire logic [3:0] REQ_BE_I,
  input wire logic [5:0] RD_STROBE_SETUP_I,
  input wire logic [6:0] RD_STROBE_PULSE_I,
  input wire logic [8:0] RD_CYCLE_LEN_I,
  input wire logic [5:0] CS_RD_SETUP_I,
  input wire logic [6:0] CS_RD_PULSE_I,
  input wire logic [5:0] WR_STROBE_SETUP_I,
  input wire logic [6:0] WR_STROBE_PULSE_I,
  input wire logic [8:0] WR_CYCLE_LEN_I,
  input wire logic [5:0] CS_WR_SETUP_I,
  input wire logic [6:0] CS_WR_PULSE_I,
  input wire logic READ_MODE_I,
  input wire logic WRITE_MODE_I,
  input wire logic [1:0] WAIT_MODE_SEL_I,
  input wire logic PAGE_MODE_EN_I,
  input wire logic [1:0] PAGE_SIZE_SEL_I,
  input wire logic BYTE_ACCESS_TYPE_I,
  input wire logic [1:0] DATA_BUS_WIDTH_I,
  input wire logic SLOW_CLOCK_I,
  input wire logic EXT_WAIT_N_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  output logic [7:0] CHIP_SEL_N_O,
  output logic READ_STROBE_N_O,
  output logic WRITE_STROBE_N_O,
  output logic [3:0] BYTE_SEL_N_O,
  output logic [25:0] MEM_ADDR_O
);
  // length decoders shared by read and write paths
  function automatic logic [7:0] setup_len(input logic [5:0] f);
    setup_len = {f[5], 2'b00, f[4:0]};
  endfunction

  function automatic logic [8:0] pulse_len(input logic [6:0] f);
    pulse_len = {f[6], 2'b00, f[5:0]};
  endfunction

  function automatic logic [9:0] cycle_len(input logic [8:0] f);
    cycle_len = {1'b0, f};
  endfunction

  // same page when bits above the page offset agree
  function automatic logic page_match(input logic [25:0] a,
    input logic [25:0] b, input logic [1:0] ps);
    logic [25:0] mask;
    mask = 26'h3ff_ffff << (PAGE_BASE_LSB + int'(ps)); // R25
    page_match = ((a ^ b) & mask) == 26'h000_0000; // R16
  endfunction

  ctrl_state_t state_r, state_nxt;
  logic [9:0] cyc_r, cyc_nxt;
  logic write_r, slow_r, page_r, hit_r, last_slow_r;
  logic [2:0] cs_r;
  logic [25:0] addr_r;
  logic [3:0] be_r;
  logic wait_n_sync;

  ext_wait_sync u_wait_sync (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .ext_wait_n_i(EXT_WAIT_N_I),
    .wait_n_sync_o(wait_n_sync)
  );

  // request acceptance and page hit test
  wire take = REQ_VALID_I & REQ_READY_O;
  wire page_req = PAGE_MODE_EN_I & ~REQ_WRITE_I & ~SLOW_CLOCK_I; // R15
  wire hit_w = (state_r == ST_PAGE_OPEN) & page_req
    & (REQ_CS_I == cs_r) // R21
    & page_match(REQ_ADDR_I, addr_r, PAGE_SIZE_SEL_I); // R21
  wire slow_change = SLOW_CLOCK_I != last_slow_r;

  // page access length: long first access, short in-page access
  wire [8:0] acc_len = hit_r ? pulse_len(RD_STROBE_PULSE_I)
    : pulse_len(CS_RD_PULSE_I); // R19

  // waveform selection: page, slow or programmed
  wire [7:0] prog_s_set = write_r ? setup_len(WR_STROBE_SETUP_I)
    : setup_len(RD_STROBE_SETUP_I);
  wire [8:0] prog_s_len = write_r ? pulse_len(WR_STROBE_PULSE_I)
    : pulse_len(RD_STROBE_PULSE_I);
  wire [7:0] prog_c_set = write_r ? setup_len(CS_WR_SETUP_I)
    : setup_len(CS_RD_SETUP_I);
  wire [8:0] prog_c_len = write_r ? pulse_len(CS_WR_PULSE_I)
    : pulse_len(CS_RD_PULSE_I);
  wire [9:0] prog_total = write_r ? cycle_len(WR_CYCLE_LEN_I)
    : cycle_len(RD_CYCLE_LEN_I);
  wire [8:0] slow_c_len = write_r ? SLOW_CS_WR_PULSE
    : SLOW_CS_RD_PULSE; // R12 R13
  wire [9:0] slow_total = write_r ? SLOW_WR_CYCLE : SLOW_RD_CYCLE;

  // page reads ignore setups and cycle length entirely
  wire [7:0] s_set = page_r ? 8'h00
    : slow_r ? SLOW_STRB_SETUP : prog_s_set; // R11 R18
  wire [8:0] s_len = page_r ? acc_len
    : slow_r ? SLOW_STRB_PULSE : prog_s_len; // R18
  wire [7:0] c_set = page_r ? 8'h00
    : slow_r ? SLOW_CS_SETUP : prog_c_set; // R11
  wire [8:0] c_len = page_r ? acc_len
    : slow_r ? slow_c_len : prog_c_len; // R19
  wire [9:0] total = page_r ? {1'b0, acc_len}
    : slow_r ? slow_total : prog_total; // R14

  // controlling signal: strobe when mode bit set, else chip select
  wire strb_ctrl = write_r ? WRITE_MODE_I : READ_MODE_I; // R24
  wire [7:0] ctrl_set = strb_ctrl ? s_set : c_set;
  wire [8:0] ctrl_len = strb_ctrl ? s_len : c_len;
  wire [9:0] ctrl_end = {2'b00, ctrl_set} + {1'b0, ctrl_len};
  wire in_pulse = (cyc_r >= {2'b00, ctrl_set}) & (cyc_r < ctrl_end);
  wire last_pulse = cyc_r == (ctrl_end - 10'h001);

  // wait handling; disabled in slow and page accesses as a safe default
  wire [1:0] wmode = (slow_r | page_r) ? WAIT_OFF
    : WAIT_MODE_SEL_I; // R1 R2
  wire wait_on = ~wait_n_sync;
  wire frozen_stall = (wmode == WAIT_FROZEN) & in_pulse
    & wait_on; // R3 R6
  wire ready_stall = (wmode == WAIT_READY) & last_pulse
    & wait_on; // R7 R8
  wire stall = (state_r == ST_ACCESS) & (frozen_stall | ready_stall);
  wire last_cyc = ({1'b0, cyc_r} + 11'h001) >= {1'b0, total};
  wire end_acc = (state_r == ST_ACCESS) & ~stall & last_cyc;

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cyc_nxt = cyc_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (take)
          state_nxt = slow_change ? ST_GAP : ST_ACCESS; // R23
        cyc_nxt = 10'h000;
      end
      ST_GAP:
      begin
        state_nxt = ST_ACCESS;
        cyc_nxt = 10'h000;
      end
      ST_ACCESS:
      begin
        if (end_acc)
        begin
          state_nxt = page_r ? ST_PAGE_OPEN : ST_IDLE;
          cyc_nxt = 10'h000;
        end
        else if (!stall)
          cyc_nxt = cyc_r + 10'h001; // R6
      end
      ST_PAGE_OPEN:
      begin
        // any other access closes the page with an idle gap
        if (take)
          state_nxt = (hit_w && !slow_change) ? ST_ACCESS : ST_GAP; // R22
        else if (!PAGE_MODE_EN_I || SLOW_CLOCK_I)
          state_nxt = ST_IDLE; // R22
        cyc_nxt = 10'h000;
      end
    endcase
  end

  // pin levels derived from state and counter
  wire s_act = ((state_r == ST_ACCESS) & (cyc_r >= {2'b00, s_set})
    & (cyc_r < ({2'b00, s_set} + {1'b0, s_len})))
    | (state_r == ST_PAGE_OPEN); // R18
  wire c_act = ((state_r == ST_ACCESS) & (cyc_r >= {2'b00, c_set})
    & (cyc_r < ({2'b00, c_set} + {1'b0, c_len})))
    | (state_r == ST_PAGE_OPEN); // R18
  wire [7:0] cs_n_nxt = c_act ? ~(8'h01 << cs_r) : 8'hff;
  wire rd_n_nxt = ~(s_act & ~write_r);
  wire wr_n_nxt = ~(s_act & write_r);
  wire [3:0] bs_n_nxt = (c_act & (BYTE_ACCESS_TYPE_I == BAT_BYTE_SEL))
    ? ~be_r : 4'hf; // R20
  wire [25:0] addr_out = (DATA_BUS_WIDTH_I == BUS_W32)
    ? {addr_r[25:2], 2'b00}
    : (DATA_BUS_WIDTH_I == BUS_W16) ? {addr_r[25:1], 1'b0}
    : addr_r; // R17
  wire ready_nxt = (state_nxt == ST_IDLE) | (state_nxt == ST_PAGE_OPEN);

  // state and counter registers
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      state_r <= ST_IDLE;
      cyc_r <= 10'h000;
    end
    else
    begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // request latch; slow flag frozen for the whole transfer
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      write_r <= 1'b0;
      slow_r <= 1'b0;
      page_r <= 1'b0;
      hit_r <= 1'b0;
      cs_r <= 3'h0;
      addr_r <= 26'h000_0000;
      be_r <= 4'h0;
    end
    else if (take)
    begin
      write_r <= REQ_WRITE_I;
      slow_r <= SLOW_CLOCK_I; // R14
      page_r <= page_req; // R15
      hit_r <= hit_w & ~slow_change; // R21
      cs_r <= REQ_CS_I;
      addr_r <= REQ_ADDR_I;
      be_r <= REQ_BE_I;
    end
  end

  // remembers the clock mode of the last transfer
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
      last_slow_r <= 1'b0;
    else if (state_r == ST_GAP)
      last_slow_r <= slow_r; // R23
  end

  // registered pins; everything inactive out of reset
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      REQ_READY_O <= 1'b0;
      DONE_O <= 1'b0;
      CHIP_SEL_N_O <= 8'hff;
      READ_STROBE_N_O <= 1'b1;
      WRITE_STROBE_N_O <= 1'b1;
      BYTE_SEL_N_O <= 4'hf;
      MEM_ADDR_O <= 26'h000_0000;
    end
    else
    begin
      REQ_READY_O <= ready_nxt;
      DONE_O <= end_acc;
      CHIP_SEL_N_O <= cs_n_nxt;
      READ_STROBE_N_O <= rd_n_nxt;
      WRITE_STROBE_N_O <= wr_n_nxt;
      BYTE_SEL_N_O <= bs_n_nxt;
      MEM_ADDR_O <= addr_out;
    end
  end

  property p_wait_off;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (state_r == ST_ACCESS && wmode == WAIT_OFF) |-> !stall;
  endproperty
  a_wait_off: assert property (p_wait_off) // R1
    else $error("stall with wait disabled");

  property p_pulse_only;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    stall |-> in_pulse;
  endproperty
  a_pulse_only: assert property (p_pulse_only) // R3
    else $error("stall outside controlling pulse");

  property p_frozen_hold;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (stall && wmode == WAIT_FROZEN) |=> $stable(cyc_r)
      ##1 ($stable(READ_STROBE_N_O) && $stable(CHIP_SEL_N_O));
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) // R6
    else $error("frozen wait did not hold state");

  property p_ready_point;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (stall && wmode == WAIT_READY) |-> last_pulse && !end_acc;
  endproperty
  a_ready_point: assert property (p_ready_point) // R7
    else $error("ready stall away from last pulse cycle");

  property p_slow_read;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (state_r == ST_ACCESS && cyc_r == 10'h000 && slow_r && !write_r
      && wait_n_sync) |-> ##1 end_acc ##1 DONE_O;
  endproperty
  a_slow_read: assert property (p_slow_read) // R12
    else $error("slow read is not two cycles");

  property p_slow_write;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (state_r == ST_ACCESS && cyc_r == 10'h000 && slow_r && write_r)
      |-> !end_acc ##1 !end_acc ##1 end_acc;
  endproperty
  a_slow_write: assert property (p_slow_write) // R13
    else $error("slow write is not three cycles");

  property p_page_low;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (state_r == ST_ACCESS && page_r) |=>
      (!READ_STROBE_N_O && READ_STROBE_N_O == CHIP_SEL_N_O[cs_r]);
  endproperty
  a_page_low: assert property (p_page_low) // R18
    else $error("page read strobes not low together");

  property p_reload;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (take && slow_change) |=> state_r == ST_GAP ##1 state_r == ST_ACCESS;
  endproperty
  a_reload: assert property (p_reload) // R23
    else $error("no wait state on clock mode change");
endmodule // static_mem_ctrl
